// [src/smw_monitor.sv]
// clock-stretch and timeout monitor for a two-wire management bus controller
// assumes: link_clk_in free-running sample clock for the bus pins; controller
// logic on clock_in supplies its own stretch/drive state and end-of-transfer
//
// Function
// (R01) controller extension accumulates per byte: start-ack, ack-ack, ack-stop
// (R02) controller extension per byte stays within budget; overlap excess tolerated
// (R03) on target violation, abort by STOP after current byte completes
// (R04) no target violation from combined low time during arbitration
// (R05) arbitration to the ARP address may span several bytes
// (R06) timeout detection configurable, including fully off
// (R07) shared-address combined stretching is not a fault
// (R08) single low-interval timeout is preferred abort for revision 2.0 parts
// (R09) target cumulative extension per message stays under its limit
// (R10) data stuck low after end: hold clock low reset time
// (R11) controller budget is 10 ms per byte
// (R12) target cumulative extension over a message is at most 25 ms
// (R13) single low interval over 25 ms aborts; recover by 35 ms
// (R14) low timer restarts on clock rise; byte budget clears at boundaries
`timescale 1ns/10ps
`default_nettype none
module smw_monitor
  import smw_pkg::*;
#(
  parameter int P_CEXT_CYC  = smw_pkg::CEXT_CYC,
  parameter int P_TEXT_CYC  = smw_pkg::TEXT_CYC,
  parameter int P_ABORT_CYC = smw_pkg::ABORT_CYC,
  parameter int P_RESET_CYC = smw_pkg::RESET_CYC
) (
  // system clock and reset
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  // link sample clock and bus pins
  input  wire logic             link_clk_in,
  input  wire logic             smb_clk_in,
  input  wire logic             smb_dat_in,
  output logic                  smb_clk_out,
  output logic                  smb_clk_oe_n_out,
  // controller status and configuration
  input  wire smw_pkg::smw_tmo_e tmo_mode_in,
  input  wire logic             ctrl_stretch_in,
  input  wire logic             own_clk_low_in,
  input  wire logic             arb_phase_in,
  input  wire logic             shared_addr_in,
  input  wire logic             xfer_end_in,
  // results
  output logic                  abort_stop_out,
  output logic                  cext_viol_out,
  output logic                  text_viol_out,
  output logic                  low_tmo_out,
  output logic                  recover_out
);

  import smw_pkg::*;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    sat_inc = (&c) ? c : c + 1'b1;
  endfunction : sat_inc

  function automatic logic at_lim(input logic [CNT_W-1:0] c, input int lim);
    at_lim = (c == CNT_W'(lim - 1));
  endfunction : at_lim

  // ---------------------------------------------------------------
  // link domain: pin sampling and framing
  // ---------------------------------------------------------------
  logic [1:0] pin_s;
  logic       lrst_s;
  logic       l_scl_ff, l_sda_ff, nxt_l_scl, nxt_l_sda;
  logic       in_msg_ff, nxt_in_msg;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  smw_link_s  lk_ff, nxt_lk;

  smw_sync #(.WIDTH(2)) u_pin_sync (
    .clk_in (link_clk_in),
    .d_in   ({smb_clk_in, smb_dat_in}),
    .q_out  (pin_s)
  );

  smw_sync #(.WIDTH(1)) u_rst_sync (
    .clk_in (link_clk_in),
    .d_in   (sys_rst_in),
    .q_out  (lrst_s)
  );

  always_comb begin
    nxt_l_scl   = pin_s[1];
    nxt_l_sda   = pin_s[0];
    nxt_in_msg  = in_msg_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_lk      = lk_ff;
    nxt_lk.scl  = l_scl_ff;
    nxt_lk.sda  = l_sda_ff;
    if (l_scl_ff && pin_s[1] && l_sda_ff && !pin_s[0]) begin
      nxt_in_msg     = 1'b1;
      nxt_bit_cnt    = 4'h0;
      nxt_lk.start_t = ~lk_ff.start_t;
    end else if (l_scl_ff && pin_s[1] && !l_sda_ff && pin_s[0]) begin
      nxt_in_msg    = 1'b0;
      nxt_lk.stop_t = ~lk_ff.stop_t;
    end else if (in_msg_ff && !l_scl_ff && pin_s[1]) begin
      if (bit_cnt_ff == ACK_BIT) begin
        nxt_bit_cnt  = 4'h0;
        nxt_lk.ack_t = ~lk_ff.ack_t;
      end else begin
        nxt_bit_cnt = bit_cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (lrst_s) begin
      l_scl_ff   <= 1'b1;
      l_sda_ff   <= 1'b1;
      in_msg_ff  <= 1'b0;
      bit_cnt_ff <= 4'h0;
      lk_ff      <= '{start_t: 1'b0, stop_t: 1'b0, ack_t: 1'b0, scl: 1'b1, sda: 1'b1};
    end else begin
      l_scl_ff   <= nxt_l_scl;
      l_sda_ff   <= nxt_l_sda;
      in_msg_ff  <= nxt_in_msg;
      bit_cnt_ff <= nxt_bit_cnt;
      lk_ff      <= nxt_lk;
    end
  end

  // ---------------------------------------------------------------
  // system domain: timers, verdicts, recovery
  // ---------------------------------------------------------------
  smw_link_s        lk_s, lk_d_ff;
  logic             ev_start, ev_stop, ev_ack, ev_bound, scl_s, sda_s, suppress;
  logic [CNT_W-1:0] low_cnt_ff, cext_cnt_ff, text_cnt_ff, rec_cnt_ff;
  logic [CNT_W-1:0] nxt_low_cnt, nxt_cext_cnt, nxt_text_cnt, nxt_rec_cnt;
  logic             abort_pend_ff, nxt_abort_pend, hit_low, hit_text;
  logic             nxt_abort_stop, nxt_cext_viol, nxt_text_viol, nxt_low_tmo;
  logic             nxt_oe_n;
  smw_rec_e         rec_ff, nxt_rec;

  smw_sync #(.WIDTH(LINK_W)) u_link_sync (
    .clk_in (clock_in),
    .d_in   (lk_ff),
    .q_out  (lk_s)
  );

  assign ev_start = lk_s.start_t ^ lk_d_ff.start_t;
  assign ev_stop  = lk_s.stop_t ^ lk_d_ff.stop_t;
  assign ev_ack   = lk_s.ack_t ^ lk_d_ff.ack_t;
  assign ev_bound = ev_start | ev_stop | ev_ack;
  assign scl_s    = lk_s.scl;
  assign sda_s    = lk_s.sda;
  // (R04) (R05) (R07) combined stretching excluded
  assign suppress = arb_phase_in | shared_addr_in;
  // (R06) (R13) single low interval verdict
  assign hit_low  = (tmo_mode_in != TMO_OFF) && !scl_s && at_lim(low_cnt_ff, P_ABORT_CYC);
  // (R08) (R09) (R12) cumulative verdict only in full mode
  assign hit_text = (tmo_mode_in == TMO_FULL) && !scl_s && !own_clk_low_in && !suppress
                    && at_lim(text_cnt_ff, P_TEXT_CYC);

  always_comb begin
    // (R14) low timer restart
    nxt_low_cnt  = scl_s ? '0 : sat_inc(low_cnt_ff);
    nxt_cext_cnt = cext_cnt_ff;
    nxt_text_cnt = text_cnt_ff;
    // (R01) (R14) per-byte accumulation; target extension accumulates per message
    if (ev_bound) begin
      nxt_cext_cnt = '0;
    end else if (ctrl_stretch_in && !scl_s) begin
      nxt_cext_cnt = sat_inc(cext_cnt_ff);
    end
    if (ev_start || ev_stop) begin
      nxt_text_cnt = '0;
    end else if (!scl_s && !own_clk_low_in && !suppress) begin
      nxt_text_cnt = sat_inc(text_cnt_ff);
    end
    // (R02) (R11) budget flag; the byte boundary wins over a new hit
    nxt_cext_viol = cext_viol_out;
    if (ctrl_stretch_in && !scl_s && !ev_bound && at_lim(cext_cnt_ff, P_CEXT_CYC)) begin
      nxt_cext_viol = 1'b1;
    end else if (ev_bound) begin
      nxt_cext_viol = 1'b0;
    end
    nxt_text_viol = hit_text ? 1'b1 : (ev_start ? 1'b0 : text_viol_out);
    nxt_low_tmo   = hit_low ? 1'b1 : (ev_start ? 1'b0 : low_tmo_out);
    // (R03) stop only once the byte in flight has finished
    nxt_abort_stop = abort_pend_ff && ev_ack;
    nxt_abort_pend = abort_pend_ff;
    if (hit_low || hit_text) begin
      nxt_abort_pend = 1'b1;
    end else if (nxt_abort_stop || ev_stop) begin
      nxt_abort_pend = 1'b0;
    end
    // (R10) (R13) stuck-data recovery
    nxt_rec     = rec_ff;
    nxt_rec_cnt = rec_cnt_ff;
    case (rec_ff)
      REC_IDLE: begin
        nxt_rec_cnt = '0;
        if (xfer_end_in) begin
          nxt_rec = REC_WATCH;
        end
      end
      REC_WATCH: begin
        if (sda_s || !scl_s) begin
          nxt_rec = REC_IDLE;
        end else if (at_lim(rec_cnt_ff, P_RESET_CYC)) begin
          nxt_rec     = REC_HOLD;
          nxt_rec_cnt = '0;
        end else begin
          nxt_rec_cnt = rec_cnt_ff + 1'b1;
        end
      end
      REC_HOLD: begin
        if (at_lim(rec_cnt_ff, P_RESET_CYC)) begin
          nxt_rec = REC_IDLE;
        end else begin
          nxt_rec_cnt = rec_cnt_ff + 1'b1;
        end
      end
      default: nxt_rec = REC_IDLE;
    endcase
    nxt_oe_n = (nxt_rec != REC_HOLD);
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      lk_d_ff          <= '{start_t: 1'b0, stop_t: 1'b0, ack_t: 1'b0, scl: 1'b1, sda: 1'b1};
      low_cnt_ff       <= '0;
      cext_cnt_ff      <= '0;
      text_cnt_ff      <= '0;
      rec_cnt_ff       <= '0;
      rec_ff           <= REC_IDLE;
      abort_pend_ff    <= 1'b0;
      abort_stop_out   <= 1'b0;
      cext_viol_out    <= 1'b0;
      text_viol_out    <= 1'b0;
      low_tmo_out      <= 1'b0;
      recover_out      <= 1'b0;
      smb_clk_out      <= 1'b0;
      smb_clk_oe_n_out <= 1'b1;
    end else begin
      lk_d_ff          <= lk_s;
      low_cnt_ff       <= nxt_low_cnt;
      cext_cnt_ff      <= nxt_cext_cnt;
      text_cnt_ff      <= nxt_text_cnt;
      rec_cnt_ff       <= nxt_rec_cnt;
      rec_ff           <= nxt_rec;
      abort_pend_ff    <= nxt_abort_pend;
      abort_stop_out   <= nxt_abort_stop;
      cext_viol_out    <= nxt_cext_viol;
      text_viol_out    <= nxt_text_viol;
      low_tmo_out      <= nxt_low_tmo;
      recover_out      <= (nxt_rec != REC_IDLE);
      smb_clk_out      <= 1'b0;
      smb_clk_oe_n_out <= nxt_oe_n;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_low_restart: assert property (scl_s |=> low_cnt_ff == '0) // (R14)
    else $error("low timer not restarted by clock high");
  a_byte_clear: assert property (ev_bound |=> cext_cnt_ff == '0) // (R01)
    else $error("byte budget not cleared at boundary");
  a_single_abort: assert property (hit_low |=> abort_pend_ff && low_tmo_out) // (R13)
    else $error("low timeout did not arm abort");
  a_stop_after_byte: assert property ($rose(abort_stop_out) |-> $past(ev_ack, 1)) // (R03)
    else $error("abort stop not at byte end");
  a_stop_issued: assert property (abort_pend_ff && ev_ack |=> abort_stop_out ##1 !abort_pend_ff) // (R03)
    else $error("pending abort did not issue stop");
  a_mode_off: assert property (tmo_mode_in == TMO_OFF && !abort_pend_ff |=> !abort_pend_ff) // (R06)
    else $error("abort armed while timeouts disabled");
  a_single_only: assert property (tmo_mode_in == TMO_SINGLE |=> !$rose(text_viol_out)) // (R08)
    else $error("cumulative verdict in single mode");
  a_arb_suppress: assert property (suppress && !ev_start && !ev_stop |=> $stable(text_cnt_ff)) // (R04)
    else $error("target extension counted during arbitration");
  a_cext_budget: assert property (ctrl_stretch_in && !scl_s && !ev_bound
    && cext_cnt_ff == CNT_W'(P_CEXT_CYC - 1) |=> cext_viol_out) // (R11)
    else $error("controller budget overrun not flagged");
  a_recover_drive: assert property ($fell(smb_clk_oe_n_out) |-> $past(!sda_s && scl_s, 1)) // (R10)
    else $error("clock hold started without stuck data");

  c_abort_stop: cover property (abort_pend_ff ##[1:1000] abort_stop_out);
  c_recover: cover property ($fell(smb_clk_oe_n_out));
  c_cext_viol: cover property ($rose(cext_viol_out));
  c_text_viol: cover property ($rose(text_viol_out));

endmodule : smw_monitor
`default_nettype wire

// [src/smw_pkg.sv]
// package for the clock-stretch and timeout monitor of a two-wire management bus
// assumes a 200 MHz system clock; every timing count below is derived from it
package smw_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  // controller's own extension budget per byte
  localparam int CEXT_TIME_US  = 10000;
  // cumulative target extension per message
  localparam int TEXT_TIME_US  = 25000;
  // clock_low_abort_time
  localparam int ABORT_TIME_US = 25000;
  // clock_low_reset_time
  localparam int RESET_TIME_US = 35000;
  localparam int CEXT_CYC      = CEXT_TIME_US * CLK_MHZ;
  localparam int TEXT_CYC      = TEXT_TIME_US * CLK_MHZ;
  localparam int ABORT_CYC     = ABORT_TIME_US * CLK_MHZ;
  localparam int RESET_CYC     = RESET_TIME_US * CLK_MHZ;
  localparam int CNT_W         = 23;

  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  // index of the ninth clock rise of a byte, the acknowledge bit
  localparam logic [3:0] ACK_BIT = 4'h8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {TMO_OFF, TMO_SINGLE, TMO_FULL} smw_tmo_e;
  typedef enum logic [1:0] {REC_IDLE, REC_WATCH, REC_HOLD} smw_rec_e;

  // link-side events travel as toggles plus the sampled line levels
  typedef struct packed {
    logic start_t;
    logic stop_t;
    logic ack_t;
    logic scl;
    logic sda;
  } smw_link_s;

  localparam int LINK_W = $bits(smw_link_s);

endpackage : smw_pkg

// [src/smw_sync.sv]
// two-stage synchroniser for a vector of levels or toggles
// assumes each bit changes at most once per few destination clocks
`timescale 1ns/10ps
`default_nettype none
module smw_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input  wire logic             clk_in,
  // asynchronous data
  input  wire logic [WIDTH-1:0] d_in,
  // synchronised data
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_ff;

  // no reset: the first stage feeds only the second
  always_ff @(posedge clk_in) begin
    meta_ff <= d_in;
    q_out   <= meta_ff;
  end

endmodule : smw_sync
`default_nettype wire

// [dv/smw_bus_model.sv]
// partner model: target devices on the two-wire bus, pins as wire levels
// assumes the bench calls its tasks and the link clock runs free
`timescale 1ns/10ps
`default_nettype none
module smw_bus_model (
  // link clock and the monitor's clock-line enable
  input  wire logic link_clk_in,
  input  wire logic clk_oe_n_in,
  // bus line levels
  output logic      scl_out,
  output logic      sda_out
);
  logic scl_rel;
  // pull-up: the clock line reads high unless someone pulls it low
  assign scl_out = scl_rel & clk_oe_n_in;
  initial begin
    scl_rel = 1'b1;
    sda_out = 1'b1;
  end
  // edges stay at least three link clocks apart so the monitor sees them
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk_in);
    #1;
  endtask : tick
  task automatic frame_start();
    tick(3);
    sda_out = 1'b0;
    tick(3);
  endtask : frame_start
  // stretch only as long as the bench commands
  task automatic bit_cyc(input int low_len);
    scl_rel = 1'b0;
    tick(low_len);
    scl_rel = 1'b1;
    tick(3);
  endtask : bit_cyc
  // last clock rise of a transfer, with data left at level v
  task automatic last_rise(input logic v);
    scl_rel = 1'b0;
    tick(3);
    sda_out = v;
    tick(3);
    scl_rel = 1'b1;
    tick(3);
  endtask : last_rise
  task automatic frame_stop();
    last_rise(1'b0);
    sda_out = 1'b1;
    tick(3);
  endtask : frame_stop
endmodule : smw_bus_model
`default_nettype wire

// [dv/smw_monitor_bench.sv]
// self-checking bench for the clock-stretch and timeout monitor
// assumes shortened timing counts and the partner model on the pins
`timescale 1ns/10ps
`default_nettype none
module smw_monitor_bench;
  import smw_pkg::*;
  localparam int RST = 140;
  typedef struct packed {
    smw_tmo_e   mode;
    logic       cs, ol, arb, sh;
    logic [1:0] n;
    logic [7:0] len;
    logic       ec, et, el;
  } smw_row_s;
  // mode, stretch, own low, arb, shared, stretched bits, length, cext, text, low
  localparam smw_row_s ROWS [11] = '{
    '{TMO_FULL,   1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 8'h00, 1'h0, 1'h0, 1'h0},
    '{TMO_FULL,   1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 8'h1e, 1'h0, 1'h1, 1'h0},
    '{TMO_FULL,   1'h0, 1'h0, 1'h0, 1'h0, 2'h1, 8'h32, 1'h0, 1'h1, 1'h1},
    '{TMO_SINGLE, 1'h0, 1'h0, 1'h0, 1'h0, 2'h1, 8'h32, 1'h0, 1'h0, 1'h1},
    '{TMO_SINGLE, 1'h0, 1'h0, 1'h0, 1'h0, 2'h2, 8'h1e, 1'h0, 1'h0, 1'h0},
    '{TMO_OFF,    1'h0, 1'h0, 1'h0, 1'h0, 2'h1, 8'h32, 1'h0, 1'h0, 1'h0},
    '{TMO_FULL,   1'h0, 1'h0, 1'h1, 1'h0, 2'h2, 8'h1e, 1'h0, 1'h0, 1'h0},
    '{TMO_FULL,   1'h0, 1'h0, 1'h0, 1'h1, 2'h2, 8'h1e, 1'h0, 1'h0, 1'h0},
    '{TMO_FULL,   1'h0, 1'h1, 1'h0, 1'h0, 2'h2, 8'h1e, 1'h0, 1'h0, 1'h0},
    '{TMO_FULL,   1'h1, 1'h1, 1'h0, 1'h0, 2'h1, 8'h1e, 1'h1, 1'h0, 1'h0},
    '{TMO_FULL,   1'h1, 1'h1, 1'h0, 1'h0, 2'h1, 8'h0a, 1'h0, 1'h0, 1'h0}};
  logic clock_in = 1'b0, link_clk = 1'b0, rst = 1'b1, scl, sda;
  logic cs = 1'b0, ol = 1'b0, arb = 1'b0, sh = 1'b0, xend = 1'b0;
  smw_tmo_e mode = TMO_OFF;
  logic clk_o, oe_n, abort, cext, text, lowt, rec;
  int n_fail = 0, tests_run = 0, n_abort = 0, a0, t;
  smw_row_s r;
  always #2.5 clock_in = ~clock_in;
  always #6 link_clk = ~link_clk;
  always @(posedge clock_in) if (abort === 1'b1) n_abort <= n_abort + 1;
  smw_bus_model bus (.link_clk_in(link_clk), .clk_oe_n_in(oe_n), .scl_out(scl), .sda_out(sda));
  smw_monitor #(.P_CEXT_CYC(40), .P_TEXT_CYC(100), .P_ABORT_CYC(100), .P_RESET_CYC(RST)) dut (
    .clock_in(clock_in), .sys_rst_in(rst), .link_clk_in(link_clk), .smb_clk_in(scl),
    .smb_dat_in(sda), .smb_clk_out(clk_o), .smb_clk_oe_n_out(oe_n), .tmo_mode_in(mode),
    .ctrl_stretch_in(cs), .own_clk_low_in(ol), .arb_phase_in(arb), .shared_addr_in(sh),
    .xfer_end_in(xend), .abort_stop_out(abort), .cext_viol_out(cext), .text_viol_out(text),
    .low_tmo_out(lowt), .recover_out(rec));
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_cnt(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_cnt
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic sys(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : sys
  // waits while the clock-line enable holds level v, bounded
  task automatic wait_oe(input logic v);
    t = 0;
    while (oe_n === v && t < 400) begin
      sys(1);
      t++;
    end
    if (t >= 400) check_cnt(16'h0, 16'h1);
    if (t >= 400) test_done();
  endtask : wait_oe
  initial begin
    sys(10);
    check_cnt({9'h0, abort, cext, text, lowt, rec, oe_n, clk_o}, 16'h0002);
    sys(10);
    rst = 1'b0;
    sys(10);
    // ---------------------------------------------------------------
    // table of single-byte transfers
    // ---------------------------------------------------------------
    for (int i = 0; i < 11; i++) begin
      r    = ROWS[i];
      mode = r.mode;
      cs   = r.cs;
      ol   = r.ol;
      arb  = r.arb;
      sh   = r.sh;
      a0 = n_abort;
      bus.frame_start();
      for (int k = 0; k < 9; k++) begin
        bus.bit_cyc(k < r.n ? int'(r.len) : 3);
        if (k == r.n) begin
          sys(4);
          check_bit(cext, r.ec);
          check_bit(text, r.et);
          check_bit(lowt, r.el);
        end
      end
      sys(8);
      check_cnt(16'(n_abort - a0), {15'h0, r.et | r.el});
      bus.frame_stop();
      sys(8);
    end
    mode = TMO_FULL;
    cs   = 1'b0;
    ol   = 1'b0;
    arb  = 1'b0;
    sh   = 1'b0;
    // data stuck low after the last rise
    bus.last_rise(1'b0);
    // the raised clock must reach the system side before the end strobe
    sys(8);
    xend = 1'b1;
    sys(1);
    xend = 1'b0;
    check_bit(rec, 1'b1);
    wait_oe(1'b1);
    check_cnt(16'(t), 16'(RST));
    check_bit(clk_o, 1'b0);
    wait_oe(1'b0);
    check_cnt(16'(t), 16'(RST));
    check_bit(rec, 1'b0);
    bus.frame_stop();
    // data high at the end: no hold
    sys(8);
    xend = 1'b1;
    sys(1);
    xend = 1'b0;
    a0 = 0;
    repeat (2 * RST) begin
      sys(1);
      if (oe_n !== 1'b1) a0++;
    end
    check_cnt(16'(a0), 16'h0);
    check_bit(rec, 1'b0);
    // the hold above was one long low interval, so the low verdict stands
    check_bit(lowt, 1'b1);
    // reset in mid-run, long enough for the link side to see it as well
    rst = 1'b1;
    sys(12);
    check_cnt({9'h0, abort, cext, text, lowt, rec, oe_n, clk_o}, 16'h0002);
    rst = 1'b0;
    sys(2);
    check_cnt({9'h0, abort, cext, text, lowt, rec, oe_n, clk_o}, 16'h0002);
    test_done();
  end
endmodule : smw_monitor_bench
`default_nettype wire
